/* design/art_defs.svh */
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets on the special-function register bus
// ----------------------------------------------------------------------
`define ART_OFS_CONTROL     8'hc8
`define ART_OFS_RELOAD_LO   8'hca
`define ART_OFS_RELOAD_HI   8'hcb
`define ART_OFS_COUNT_LO    8'hcc
`define ART_OFS_COUNT_HI    8'hcd

// ----------------------------------------------------------------------
// timer_control field positions
// ----------------------------------------------------------------------
`define ART_BIT_HFLAG       7
`define ART_BIT_LFLAG       6
`define ART_BIT_LEN         5
`define ART_BIT_CEN         4
`define ART_BIT_SPLIT       3
`define ART_BIT_RUN         2
`define ART_BIT_UNUSED      1
`define ART_BIT_XCLK        0

// ----------------------------------------------------------------------
// reset values and byte limits
// ----------------------------------------------------------------------
`define ART_RST_BYTE        8'h00
`define ART_BYTE_ALL_ONES   8'hff

// ----------------------------------------------------------------------
// tick dividers
// ----------------------------------------------------------------------
`define ART_SYS_DIV         12
`define ART_EXT_DIV         8
`define ART_SYS_DIV_LAST    4'hb
`define ART_EXT_DIV_LAST    3'h7

`endif

/* design/art_pkg.sv */
`default_nettype none

// ----------------------------------------------------------------------
// shared types
// ----------------------------------------------------------------------
package art_pkg;
   typedef logic [7:0]  art_byte_type;
   typedef logic [15:0] art_word_type;
   typedef enum logic {
      ART_MODE_WIDE,
      ART_MODE_SPLIT
   } art_mode_type;
endpackage

`default_nettype wire

/* design/art_tick_if.sv */
`default_nettype none

// ----------------------------------------------------------------------
// tick strobes from the prescaler to the counter
// ----------------------------------------------------------------------
interface art_tick_if;
   logic div12_tick;
   logic ext8_tick;
   modport gen (output div12_tick, output ext8_tick);
   modport use_side (input div12_tick, input ext8_tick);
endinterface

`default_nettype wire

/* design/art_tick.sv */
`include "art_defs.svh"
`default_nettype none

// ----------------------------------------------------------------------
// prescaler: system clock / 12 and synchronised external clock / 8
// ----------------------------------------------------------------------
module art_tick (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_ext_clk,
   art_tick_if.gen   tk
);
   logic       ext_s1_r, ext_s2_r, ext_s3_r;
   logic [3:0] sys_cnt_r, sys_cnt_nxt;
   logic [2:0] ext_cnt_r, ext_cnt_nxt;
   logic       div12_r, div12_nxt;
   logic       ext8_r, ext8_nxt;
   logic       ext_rise;

   // next values; ext_s1_r feeds only ext_s2_r to keep the synchroniser clean
   always_comb begin
      ext_rise    = ext_s2_r & ~ext_s3_r;
      div12_nxt   = (sys_cnt_r == `ART_SYS_DIV_LAST);
      sys_cnt_nxt = div12_nxt ? 4'h0 : sys_cnt_r + 4'h1;
      ext8_nxt    = ext_rise & (ext_cnt_r == `ART_EXT_DIV_LAST);
      ext_cnt_nxt = ext_rise ? ext_cnt_r + 3'h1 : ext_cnt_r;
   end

   // registers; ticks leave as single-cycle strobes in the system domain
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ext_s1_r  <= 1'b0;
         ext_s2_r  <= 1'b0;
         ext_s3_r  <= 1'b0;
         sys_cnt_r <= 4'h0;
         ext_cnt_r <= 3'h0;
         div12_r   <= 1'b0;
         ext8_r    <= 1'b0;
      end else begin
         ext_s1_r  <= i_ext_clk;
         ext_s2_r  <= ext_s1_r;
         ext_s3_r  <= ext_s2_r;
         sys_cnt_r <= sys_cnt_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         div12_r   <= div12_nxt;
         ext8_r    <= ext8_nxt;
      end
   end

   assign tk.div12_tick = div12_r;
   assign tk.ext8_tick  = ext8_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_div12_spacing: assert property (div12_r |-> ##12 div12_r)
      else $error("divide-by-12 tick spacing wrong");
   a_div12_quiet: assert property (div12_r |=> !div12_r [*8])
      else $error("divide-by-12 tick too early");
endmodule

`default_nettype wire

/* design/art_timer.sv */
// What this block does
// - wide mode counts, overflow reloads, sets high flag
// - wide mode full overflow requests interrupt
// - low-byte rollover also interrupts when enabled
// - split mode gives two 8-bit reloading timers
// - each split byte reloads its own byte
// - run gates high byte only when split
// - per-byte clock select: system_clock, /12, ext/8
// - external divide-by-8 tick is synchronised
// - high flag on high roll, low flag always
// - split mode interrupts on enabled byte overflows
// - flags cleared only by software writes
// - set high flag plus enable requests vector
// - oscillator falling edge captures count, interrupts, if capture and timer irq enable both set
// - control register field layout
// - control bit 1 reads zero, ignores writes
// - external select shared, byte override, reset clear
// - count bytes show wide or split counts
// - low select drives wide mode, high ignored
`include "art_defs.svh"
`default_nettype none

module art_timer (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic       i_sfr_wr,
   input  wire logic       i_sfr_rd,
   input  wire logic       i_timer_irq_enable,
   input  wire logic       i_low_byte_system_clock_select,
   input  wire logic       i_high_byte_system_clock_select,
   input  wire logic       i_ext_clk,
   input  wire logic       i_lfo,
   output logic      [7:0] o_sfr_rdata,
   output logic            o_irq
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   art_pkg::art_byte_type cnt_lo_r, cnt_lo_nxt;
   art_pkg::art_byte_type cnt_hi_r, cnt_hi_nxt;
   art_pkg::art_byte_type rl_lo_r, rl_lo_nxt;
   art_pkg::art_byte_type rl_hi_r, rl_hi_nxt;
   art_pkg::art_mode_type mode_r, mode_nxt;
   logic                  hflag_r, hflag_nxt;
   logic                  lflag_r, lflag_nxt;
   logic                  len_r, len_nxt;
   logic                  cen_r, cen_nxt;
   logic                  run_r, run_nxt;
   logic                  xclk_r, xclk_nxt;
   logic                  lfo_d_r;
   art_pkg::art_byte_type rdata_r, rdata_nxt;
   logic                  irq_r, irq_nxt;

   // ----------------------------------------------------------------------
   // decoded strobes and events
   // ----------------------------------------------------------------------
   logic                  split;
   logic                  wr_ctl, wr_rll, wr_rlh, wr_cl, wr_ch;
   logic                  base_tick, lo_tick, hi_tick;
   logic                  inc_lo, inc_hi, lo_ovf, hi_ovf;
   logic                  lfo_fall, cap_ev;
   art_pkg::art_byte_type ctl_view;

   // ----------------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------------
   art_tick_if tick_bus ();

   art_tick u_tick (
      .i_clk     (i_clk),
      .i_nrst    (i_nrst),
      .i_ext_clk (i_ext_clk),
      .tk        (tick_bus.gen)
   );

   // ----------------------------------------------------------------------
   // bus decode and tick selection
   // ----------------------------------------------------------------------
   always_comb begin
      split  = (mode_r == art_pkg::ART_MODE_SPLIT);
      wr_ctl = i_sfr_wr & (i_sfr_addr == `ART_OFS_CONTROL);
      wr_rll = i_sfr_wr & (i_sfr_addr == `ART_OFS_RELOAD_LO);
      wr_rlh = i_sfr_wr & (i_sfr_addr == `ART_OFS_RELOAD_HI);
      wr_cl  = i_sfr_wr & (i_sfr_addr == `ART_OFS_COUNT_LO);
      wr_ch  = i_sfr_wr & (i_sfr_addr == `ART_OFS_COUNT_HI);
      // one shared prescaler choice, each byte may override with system_clock
      base_tick = xclk_r ? tick_bus.ext8_tick : tick_bus.div12_tick;
      lo_tick   = i_low_byte_system_clock_select | base_tick;
      // outside split mode the high select is ignored
      hi_tick   = split ? (i_high_byte_system_clock_select | base_tick)
                        : lo_tick;
   end

   // ----------------------------------------------------------------------
   // counting and overflow detection
   // ----------------------------------------------------------------------
   always_comb begin
      // low byte free-runs in split mode; whole timer gated in wide mode
      inc_lo = split ? lo_tick : (run_r & lo_tick);
      lo_ovf = inc_lo & (cnt_lo_r == `ART_BYTE_ALL_ONES);
      // wide mode carries from low into high; split gates high on run
      inc_hi = split ? (run_r & hi_tick) : lo_ovf;
      hi_ovf = inc_hi & (cnt_hi_r == `ART_BYTE_ALL_ONES);
      lfo_fall = lfo_d_r & ~i_lfo;
      cap_ev   = cen_r & i_timer_irq_enable & lfo_fall;
   end

   // counter next value; a software write to a count byte beats the tick
   always_comb begin
      cnt_lo_nxt = cnt_lo_r;
      cnt_hi_nxt = cnt_hi_r;
      if (lo_ovf) begin
         // split reloads low alone; wide reloads only on the full carry
         cnt_lo_nxt = (split | hi_ovf) ? rl_lo_r : `ART_RST_BYTE;
      end else if (inc_lo) begin
         cnt_lo_nxt = cnt_lo_r + 8'h01;
      end
      if (hi_ovf) begin
         cnt_hi_nxt = rl_hi_r;
      end else if (inc_hi) begin
         cnt_hi_nxt = cnt_hi_r + 8'h01;
      end
      if (wr_cl) begin
         cnt_lo_nxt = i_sfr_wdata;
      end
      if (wr_ch) begin
         cnt_hi_nxt = i_sfr_wdata;
      end
   end

   // reload pair; an oscillator capture beats a same-cycle software write
   always_comb begin
      rl_lo_nxt = wr_rll ? i_sfr_wdata : rl_lo_r;
      rl_hi_nxt = wr_rlh ? i_sfr_wdata : rl_hi_r;
      if (cap_ev) begin
         rl_lo_nxt = cnt_lo_r;
         rl_hi_nxt = cnt_hi_r;
      end
   end

   // control register; hardware set wins over a clearing write
   always_comb begin
      hflag_nxt = wr_ctl ? i_sfr_wdata[`ART_BIT_HFLAG] : hflag_r;
      lflag_nxt = wr_ctl ? i_sfr_wdata[`ART_BIT_LFLAG] : lflag_r;
      if (hi_ovf | cap_ev) begin
         hflag_nxt = 1'b1;
      end
      if (lo_ovf) begin
         lflag_nxt = 1'b1;
      end
      len_nxt  = wr_ctl ? i_sfr_wdata[`ART_BIT_LEN] : len_r;
      cen_nxt  = wr_ctl ? i_sfr_wdata[`ART_BIT_CEN] : cen_r;
      run_nxt  = wr_ctl ? i_sfr_wdata[`ART_BIT_RUN] : run_r;
      xclk_nxt = wr_ctl ? i_sfr_wdata[`ART_BIT_XCLK] : xclk_r;
      mode_nxt = mode_r;
      if (wr_ctl) begin
         mode_nxt = i_sfr_wdata[`ART_BIT_SPLIT] ? art_pkg::ART_MODE_SPLIT
                                                : art_pkg::ART_MODE_WIDE;
      end
   end

   // ----------------------------------------------------------------------
   // read data and interrupt request
   // ----------------------------------------------------------------------
   always_comb begin
      ctl_view = `ART_RST_BYTE;
      ctl_view[`ART_BIT_HFLAG]  = hflag_r;
      ctl_view[`ART_BIT_LFLAG]  = lflag_r;
      ctl_view[`ART_BIT_LEN]    = len_r;
      ctl_view[`ART_BIT_CEN]    = cen_r;
      ctl_view[`ART_BIT_SPLIT]  = split;
      ctl_view[`ART_BIT_RUN]    = run_r;
      ctl_view[`ART_BIT_UNUSED] = 1'b0;
      ctl_view[`ART_BIT_XCLK]   = xclk_r;
      rdata_nxt = rdata_r;
      if (i_sfr_rd) begin
         unique case (i_sfr_addr)
            `ART_OFS_CONTROL:   rdata_nxt = ctl_view;
            `ART_OFS_RELOAD_LO: rdata_nxt = rl_lo_r;
            `ART_OFS_RELOAD_HI: rdata_nxt = rl_hi_r;
            `ART_OFS_COUNT_LO:  rdata_nxt = cnt_lo_r;
            `ART_OFS_COUNT_HI:  rdata_nxt = cnt_hi_r;
            default:            rdata_nxt = `ART_RST_BYTE;  // foreign address
         endcase
      end
      // level request: held while a flag stands, so no event is missed
      irq_nxt = i_timer_irq_enable & (hflag_r | (len_r & lflag_r));
      // the same level serves the low byte once its enable is set
      // and both split byte overflows, by way of the two flags
      // and the vector request while the high flag stands
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_lo_r <= `ART_RST_BYTE;
         cnt_hi_r <= `ART_RST_BYTE;
         rl_lo_r  <= `ART_RST_BYTE;
         rl_hi_r  <= `ART_RST_BYTE;
         mode_r   <= art_pkg::ART_MODE_WIDE;
         hflag_r  <= 1'b0;
         lflag_r  <= 1'b0;
         len_r    <= 1'b0;
         cen_r    <= 1'b0;
         run_r    <= 1'b0;
         xclk_r   <= 1'b0;
         lfo_d_r  <= 1'b0;
         rdata_r  <= `ART_RST_BYTE;
         irq_r    <= 1'b0;
      end else begin
         cnt_lo_r <= cnt_lo_nxt;
         cnt_hi_r <= cnt_hi_nxt;
         rl_lo_r  <= rl_lo_nxt;
         rl_hi_r  <= rl_hi_nxt;
         mode_r   <= mode_nxt;
         hflag_r  <= hflag_nxt;
         lflag_r  <= lflag_nxt;
         len_r    <= len_nxt;
         cen_r    <= cen_nxt;
         run_r    <= run_nxt;
         xclk_r   <= xclk_nxt;
         lfo_d_r  <= i_lfo;
         rdata_r  <= rdata_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign o_sfr_rdata = rdata_r;
   assign o_irq       = irq_r;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   logic quiet_bus;
   assign quiet_bus = !i_sfr_wr;

   a_wide_reload: assert property (
      !split && run_r && lo_tick && {cnt_hi_r, cnt_lo_r} == 16'hffff && quiet_bus
      && !cap_ev |=> {cnt_hi_r, cnt_lo_r} == $past({rl_hi_r, rl_lo_r}) && hflag_r)
      else $error("wide overflow did not reload or flag");
   a_wide_irq: assert property (
      hi_ovf && i_timer_irq_enable |=> ##1 o_irq || !$past(i_timer_irq_enable))
      else $error("overflow did not raise request");
   a_low_irq: assert property (
      lflag_r && len_r && i_timer_irq_enable |=> o_irq)
      else $error("low flag with enable did not request");
   a_split_lo_free: assert property (
      split && !run_r && lo_tick && cnt_lo_r != 8'hff && quiet_bus
      |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
      else $error("split low byte did not count");
   a_split_hi_hold: assert property (
      split && !run_r && quiet_bus |=> $stable(cnt_hi_r))
      else $error("split high byte moved while stopped");
   a_split_lo_rel: assert property (
      split && lo_ovf && quiet_bus && !cap_ev |=> cnt_lo_r == $past(rl_lo_r) && lflag_r)
      else $error("split low byte did not reload");
   a_flag_sticky: assert property (
      hflag_r && !wr_ctl |=> hflag_r)
      else $error("high flag dropped without software");
   a_unused_zero: assert property (
      i_sfr_rd && i_sfr_addr == `ART_OFS_CONTROL |=> !o_sfr_rdata[`ART_BIT_UNUSED])
      else $error("unused control bit read nonzero");
   a_capture: assert property (
      cap_ev |=> {rl_hi_r, rl_lo_r} == $past({cnt_hi_r, cnt_lo_r}) && hflag_r)
      else $error("capture did not copy count");

   // overflow, stop and enable checks beyond the basic paths
   a_split_hi_rel: assert property (
      split && hi_ovf && quiet_bus |=> cnt_hi_r == $past(rl_hi_r) && hflag_r)
      else $error("split high byte did not reload");
   a_wide_lo_roll: assert property (
      !split && lo_ovf && !hi_ovf && quiet_bus |=> cnt_lo_r == 8'h00 && lflag_r)
      else $error("wide low rollover did not clear or flag");
   a_low_flag_set: assert property (
      lo_ovf |=> lflag_r)
      else $error("low rollover did not set low flag");
   a_wide_stop: assert property (
      !split && !run_r && quiet_bus |=> $stable({cnt_hi_r, cnt_lo_r}))
      else $error("wide timer moved while stopped");
   a_split_irq_hi: assert property (
      split && hflag_r && i_timer_irq_enable |=> o_irq)
      else $error("split high overflow did not request");
   a_irq_masked: assert property (
      !i_timer_irq_enable |=> !o_irq)
      else $error("request raised while timer interrupt disabled");
   a_cap_gated: assert property (
      !i_timer_irq_enable && quiet_bus |=> $stable({rl_hi_r, rl_lo_r}))
      else $error("reload pair changed with capture gated off");

   c_wide_ovf:  cover property (!split && hi_ovf);
   c_split_two: cover property (split && lo_ovf ##[1:600] split && hi_ovf);
   c_capture:   cover property (cap_ev);
   c_irq:       cover property (!o_irq ##1 o_irq);
   c_low_irq:   cover property (len_r && lflag_r && !hflag_r ##2 o_irq);
endmodule

`default_nettype wire

/* test/art_core_model.sv */
`default_nettype none

// ----------------------------------------------------------------------
// processor core side of the special-function register bus
// ----------------------------------------------------------------------
module art_core_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle from time zero
   initial begin
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // one-cycle write strobe, launched and dropped on falling edges
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clk);
      o_wr    = 1'b0;
      o_addr  = ~a;   // released lines must not keep the old value
      o_wdata = ~d;
   endtask

   // read data is registered, so it is taken one falling edge later
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clk);
      o_rd   = 1'b0;
      o_addr = ~a;
      @(negedge i_clk);
      d = i_rdata;
   endtask

   // software inspects both flags, then clears them itself
   task automatic service_flags(output logic [7:0] ctl);
      sfr_read(8'hc8, ctl);
      sfr_write(8'hc8, ctl & 8'h3f);
   endtask
endmodule

`default_nettype wire

/* test/auto_reload_timer_split_capture_test.sv */
`include "art_defs.svh"
`default_nettype none

module auto_reload_timer_split_capture_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic       i_clk   = 1'b0;
   logic       i_nrst  = 1'b0;
   logic       irq_en  = 1'b0;
   logic       lsel    = 1'b0;
   logic       hsel    = 1'b0;
   logic       ext_clk = 1'b0;
   logic       ext_run = 1'b0;
   logic       lfo     = 1'b0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq;
   logic [7:0] v;
   logic [7:0] regs [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
   int         n_fail     = 0;
   int         n_compared = 0;
   int         cycles     = 0;

   // 125 MHz system clock; external oscillator runs unrelated, only when asked
   always #4 i_clk = ~i_clk;
   initial begin
      #3;
      forever #20 if (ext_run) ext_clk = ~ext_clk;
   end

   art_core_model u_core (
      .i_clk   (i_clk),
      .i_rdata (rdata),
      .o_addr  (addr),
      .o_wdata (wdata),
      .o_wr    (wr),
      .o_rd    (rd)
   );

   art_timer u_dut (
      .i_clk                     (i_clk),
      .i_nrst                    (i_nrst),
      .i_sfr_addr                (addr),
      .i_sfr_wdata               (wdata),
      .i_sfr_wr                  (wr),
      .i_sfr_rd                  (rd),
      .i_timer_irq_enable        (irq_en),
      .i_low_byte_system_clock_select  (lsel),
      .i_high_byte_system_clock_select (hsel),
      .i_ext_clk                 (ext_clk),
      .i_lfo                     (lfo),
      .o_sfr_rdata               (rdata),
      .o_irq                     (irq)
   );

   // ----------------------------------------------------------------------
   // compare helpers and closing report
   // ----------------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // tick counts drift by a cycle or two with prescaler phase
   task automatic chk_range(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      n_compared++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_core.sfr_read(a, v);
      chk_byte(v, exp);
   endtask

   task automatic rd_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      u_core.sfr_read(a, v);
      chk_range(v, lo, hi);
   endtask

   // bounded wait for the request level, then compare it
   task automatic wait_irq(input logic lvl, input int lim);
      for (int k = 0; k < lim && irq !== lvl; k++) @(negedge i_clk);
      chk_byte({7'h00, irq}, {7'h00, lvl});
   endtask

   task automatic set_pins(input logic e, input logic l, input logic h);
      @(negedge i_clk);
      irq_en = e;
      lsel   = l;
      hsel   = h;
   endtask

   // a hang counts as a mismatch
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_fail++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (6) @(negedge i_clk);
      i_nrst = 1'b1;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h02);
      rd_chk(`ART_OFS_CONTROL, 8'h00);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h39);
      rd_chk(`ART_OFS_CONTROL, 8'h39);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h00);
      u_core.sfr_write(`ART_OFS_RELOAD_LO, 8'h34);
      u_core.sfr_write(`ART_OFS_RELOAD_HI, 8'h12);
      rd_chk(`ART_OFS_RELOAD_LO, 8'h34);
      rd_chk(`ART_OFS_RELOAD_HI, 8'h12);
      // wide mode: stopped, then full overflow reloads and flags
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'hfe);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'hff);
      set_pins(1'b1, 1'b1, 1'b0);
      repeat (10) @(negedge i_clk);
      rd_chk(`ART_OFS_COUNT_LO, 8'hfe);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h04);
      wait_irq(1'b1, 10);
      rd_chk(`ART_OFS_CONTROL, 8'hc4);
      rd_chk(`ART_OFS_COUNT_HI, 8'h12);
      repeat (30) @(negedge i_clk);
      chk_byte({7'h00, irq}, 8'h01);
      u_core.service_flags(v);
      chk_byte(v, 8'hc4);
      wait_irq(1'b0, 4);
      // low-byte rollover alone interrupts once enabled
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h24);
      wait_irq(1'b1, 300);
      rd_chk(`ART_OFS_CONTROL, 8'h64);
      // split mode: low byte runs without run control, own reloads
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h00);
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'hfd);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'h50);
      u_core.sfr_write(`ART_OFS_RELOAD_LO, 8'ha0);
      u_core.sfr_write(`ART_OFS_RELOAD_HI, 8'h70);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h08);
      repeat (10) @(negedge i_clk);
      chk_byte({7'h00, irq}, 8'h00);
      rd_chk(`ART_OFS_CONTROL, 8'h48);
      rd_chk(`ART_OFS_COUNT_HI, 8'h50);
      rd_rng(`ART_OFS_COUNT_LO, 8'ha0, 8'hc0);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'hfe);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h0c);
      wait_irq(1'b1, 40);
      u_core.sfr_read(`ART_OFS_CONTROL, v);
      chk_byte(v & 8'h80, 8'h80);
      rd_rng(`ART_OFS_COUNT_HI, 8'h70, 8'h7f);
      // wide mode on divide-by-12, high select must be ignored
      set_pins(1'b1, 1'b0, 1'b1);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h00);
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'h00);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'h00);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h04);
      repeat (120) @(negedge i_clk);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h00);
      rd_rng(`ART_OFS_COUNT_LO, 8'h09, 8'h0c);
      rd_chk(`ART_OFS_COUNT_HI, 8'h00);
      // external tick: still oscillator gives no ticks, running gives /8
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'h00);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h05);
      repeat (100) @(negedge i_clk);
      rd_chk(`ART_OFS_COUNT_LO, 8'h00);
      ext_run = 1'b1;
      repeat (400) @(negedge i_clk);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h01);
      ext_run = 1'b0;
      rd_rng(`ART_OFS_COUNT_LO, 8'h08, 8'h0b);
      // split mode: low on divide-by-12, high on system clock
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'h00);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'h00);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h0c);
      repeat (120) @(negedge i_clk);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h00);
      rd_rng(`ART_OFS_COUNT_LO, 8'h09, 8'h0c);
      rd_rng(`ART_OFS_COUNT_HI, 8'h78, 8'h7c);
      // oscillator falling edge captures the running count
      set_pins(1'b1, 1'b1, 1'b0);
      u_core.sfr_write(`ART_OFS_COUNT_LO, 8'h00);
      u_core.sfr_write(`ART_OFS_COUNT_HI, 8'h44);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h14);
      @(negedge i_clk);
      lfo = 1'b1;
      repeat (5) @(negedge i_clk);
      lfo = 1'b0;
      wait_irq(1'b1, 4);
      u_core.sfr_write(`ART_OFS_CONTROL, 8'h80);
      rd_chk(`ART_OFS_RELOAD_HI, 8'h44);
      rd_rng(`ART_OFS_RELOAD_LO, 8'h03, 8'h14);
      finish_test();
   end
endmodule

`default_nettype wire
